// >>> odss_top.sv
// operation data source select: axi4-lite registers, source resolution, monitor sign
`timescale 1ns/1ps
module odss_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire odss_pkg::odss_analog_t analog_in,
    input wire logic signed [15:0] detected_speed,
    input wire logic forward_run_input,
    input wire logic reverse_run_input,
    input wire logic [3:0] entry_select,
    output odss_pkg::odss_entry_t entry_out,
    output odss_pkg::odss_srcs_t entry_srcs,
    output logic [15:0] speed_monitor,
    output logic [2:0] setter_screen,
    output logic [2:0] panel_screen
);
    import odss_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic position_mode_reg, position_mode_next;
    logic [1:0] speed_display_reg, speed_display_next;
    // power-on defaults; these settings outlive rst_b like stored parameters
    logic [2:0] setter_screen_cfg_reg = ODSS_SCREEN_RST, setter_screen_cfg_next;
    logic [2:0] panel_screen_cfg_reg = ODSS_SCREEN_RST, panel_screen_cfg_next;
    logic [1:0] st_pending_reg = ODSS_SPEED_TORQUE_RST, st_pending_next;
    logic accel_pending_reg = ODSS_ACCEL_RST, accel_pending_next;
    logic [1:0] st_active_reg, st_active_next;
    logic accel_active_reg, accel_active_next;
    logic [2:0] setter_screen_reg, setter_screen_next;
    logic [2:0] panel_screen_reg, panel_screen_next;
    logic boot_done_reg, boot_done_next;

    // axi state
    logic aw_held_reg, aw_held_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic w_held_reg, w_held_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    // output state
    odss_entry_t entry_reg, entry_next;
    odss_srcs_t srcs_reg, srcs_next;
    logic [15:0] monitor_reg, monitor_next;
    logic [3:0] sel_d_reg;

    logic do_write;
    logic tbl_wr_en;
    logic [63:0] tbl_wr_data, tbl_wr_mask;
    logic [3:0] tbl_wr_addr;
    logic [63:0] tbl_rd_data;
    odss_entry_t digital_entry;
    odss_srcs_t srcs_comb;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [15:0] magnitude(input logic signed [15:0] v);
        return v[15] ? 16'(-v) : 16'(v);
    endfunction

    function automatic logic is_table(input logic [7:0] a);
        return (a >= ODSS_OFF_TABLE_BASE) && (a <= ODSS_OFF_TABLE_END);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // digital table: two words per entry, low word speed/torque, high word accel/decel
    odss_table_mem #(
        .DEPTH(ODSS_ENTRIES),
        .ADDR_W(ODSS_ENTRY_W),
        .DATA_W(4 * ODSS_DATA_W)
    ) u_table (
        .clock(clock),
        .rst_b(rst_b),
        .wr_en(tbl_wr_en),
        .wr_addr(tbl_wr_addr),
        .wr_data(tbl_wr_data),
        .wr_mask(tbl_wr_mask),
        .rd_addr(entry_select),
        .rd_data(tbl_rd_data)
    );

    always_comb
    begin
        logic [31:0] bytemask;
        bytemask = '0;
        for (int i = 0; i < 4; i++)
        begin
            bytemask[i*8 +: 8] = {8{w_strb_reg[i]}};
        end
        tbl_wr_en = do_write && is_table(aw_addr_reg);
        tbl_wr_addr = aw_addr_reg[6:3];
        tbl_wr_data = aw_addr_reg[2] ? {32'h0, w_data_reg} : {w_data_reg, 32'h0};
        tbl_wr_mask = aw_addr_reg[2] ? {32'h0, bytemask} : {bytemask, 32'h0};
    end

    assign digital_entry = odss_entry_t'(tbl_rd_data);

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write and read channels
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    always_comb
    begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        position_mode_next = position_mode_reg;
        speed_display_next = speed_display_reg;
        setter_screen_cfg_next = setter_screen_cfg_reg;
        panel_screen_cfg_next = panel_screen_cfg_reg;
        st_pending_next = st_pending_reg;
        accel_pending_next = accel_pending_reg;
        if (s_axi_awvalid && !aw_held_reg)
        begin
            aw_held_next = 1'b1;
            aw_addr_next = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && !w_held_reg)
        begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = ODSS_RESP_OKAY;
            case (aw_addr_reg)
                // every setting lives in byte 0, so only its strobe matters
                ODSS_OFF_CONTROL:
                    position_mode_next = w_strb_reg[0] ? w_data_reg[ODSS_CTRL_MODE_BIT] : position_mode_reg;
                ODSS_OFF_SPEED_DISPLAY:
                    speed_display_next = w_strb_reg[0] ? w_data_reg[1:0] : speed_display_reg;
                ODSS_OFF_SETTER_SCREEN:
                    setter_screen_cfg_next = w_strb_reg[0] ? w_data_reg[2:0] : setter_screen_cfg_reg;
                ODSS_OFF_PANEL_SCREEN:
                    panel_screen_cfg_next = w_strb_reg[0] ? w_data_reg[2:0] : panel_screen_cfg_reg;
                ODSS_OFF_SPEED_TORQUE_SRC:
                    st_pending_next = w_strb_reg[0] ? w_data_reg[1:0] : st_pending_reg;
                ODSS_OFF_ACCEL_SRC:
                    accel_pending_next = w_strb_reg[0] ? w_data_reg[0] : accel_pending_reg;
                default:
                    if (!is_table(aw_addr_reg))
                    begin
                        bresp_next = ODSS_RESP_SLVERR;
                    end
            endcase
        end
        if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next = ODSS_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                ODSS_OFF_CONTROL: rdata_next = {31'h0, position_mode_reg};
                ODSS_OFF_SPEED_DISPLAY: rdata_next = {30'h0, speed_display_reg};
                ODSS_OFF_SETTER_SCREEN: rdata_next = {29'h0, setter_screen_cfg_reg};
                ODSS_OFF_PANEL_SCREEN: rdata_next = {29'h0, panel_screen_cfg_reg};
                ODSS_OFF_SPEED_TORQUE_SRC: rdata_next = {30'h0, st_pending_reg};
                ODSS_OFF_ACCEL_SRC: rdata_next = {31'h0, accel_pending_reg};
                ODSS_OFF_ACTIVE_SRC: rdata_next = {29'h0, accel_active_reg, st_active_reg};
                ODSS_OFF_SELECTED: rdata_next = {24'h0, srcs_reg};
                ODSS_OFF_MONITOR: rdata_next = {16'h0, monitor_reg};
                default:
                begin
                    rdata_next = 32'h0;
                    // table is write-only; its effect shows on entry_out
                    rresp_next = is_table({s_axi_araddr[7:2], 2'b00}) ? ODSS_RESP_OKAY : ODSS_RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-up latch of source selectors and start screens
    always_comb
    begin
        boot_done_next = 1'b1;
        st_active_next = st_active_reg;
        accel_active_next = accel_active_reg;
        setter_screen_next = setter_screen_reg;
        panel_screen_next = panel_screen_reg;
        if (!boot_done_reg)
        begin
            // rst_b is the power-up; later writes wait for the next one
            st_active_next = st_pending_reg;
            accel_active_next = accel_pending_reg;
            // out-of-range codes fall back to speed
            setter_screen_next = (setter_screen_cfg_reg > ODSS_SCREEN_MAX) ? ODSS_SCREEN_RST
                                                                          : setter_screen_cfg_reg;
            panel_screen_next = (panel_screen_cfg_reg > ODSS_SCREEN_MAX) ? ODSS_SCREEN_RST
                                                                        : panel_screen_cfg_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source resolution for the selected entry
    always_comb
    begin
        srcs_comb = '{ODSS_SRC_DIGITAL, ODSS_SRC_DIGITAL, ODSS_SRC_DIGITAL, ODSS_SRC_DIGITAL};
        if (position_mode_reg)
        begin
            if (st_active_reg == ODSS_ST_TORQUE)
            begin
                srcs_comb.torque = ODSS_SRC_EXT_ANALOG;
            end
        end
        else
        begin
            case (st_active_reg)
                ODSS_ST_ANALOG_SPEED:
                    if (sel_d_reg == ODSS_ENTRY0)
                    begin
                        srcs_comb.speed = ODSS_SRC_INT_POT;
                    end
                    else if (sel_d_reg == ODSS_ENTRY1)
                    begin
                        srcs_comb.speed = ODSS_SRC_EXT_ANALOG;
                    end
                ODSS_ST_TORQUE:
                    if (sel_d_reg == ODSS_ENTRY0)
                    begin
                        srcs_comb.torque = ODSS_SRC_EXT_ANALOG;
                    end
                default:
                    srcs_comb.speed = ODSS_SRC_DIGITAL;
            endcase
            if (accel_active_reg && (sel_d_reg == ODSS_ENTRY0 || sel_d_reg == ODSS_ENTRY1))
            begin
                srcs_comb.accel = ODSS_SRC_TIME_POT;
                srcs_comb.decel = ODSS_SRC_TIME_POT;
            end
        end
    end

    always_comb
    begin
        srcs_next = srcs_comb;
        entry_next = digital_entry;
        case (srcs_comb.speed)
            ODSS_SRC_INT_POT: entry_next.speed = analog_in.int_pot_speed;
            ODSS_SRC_EXT_ANALOG: entry_next.speed = analog_in.ext_analog;
            default: entry_next.speed = digital_entry.speed;
        endcase
        if (srcs_comb.torque == ODSS_SRC_EXT_ANALOG)
        begin
            entry_next.torque = analog_in.ext_analog;
        end
        if (srcs_comb.accel == ODSS_SRC_TIME_POT)
        begin
            entry_next.accel = analog_in.accel_time_pot;
            entry_next.decel = analog_in.decel_time_pot;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // speed monitor sign
    always_comb
    begin
        case (speed_display_reg)
            ODSS_SIGN_ABS: monitor_next = magnitude(detected_speed);
            ODSS_SIGN_INVERSE: monitor_next = forward_run_input ? 16'(-magnitude(detected_speed))
                                                                : magnitude(detected_speed);
            ODSS_SIGN_SIGNED: monitor_next = reverse_run_input ? 16'(-magnitude(detected_speed))
                                                               : magnitude(detected_speed);
            default: monitor_next = magnitude(detected_speed);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= ODSS_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= ODSS_RESP_OKAY;
            position_mode_reg <= 1'b0;
            speed_display_reg <= ODSS_SPEED_DISPLAY_RST;
            st_active_reg <= ODSS_SPEED_TORQUE_RST;
            accel_active_reg <= ODSS_ACCEL_RST;
            setter_screen_reg <= ODSS_SCREEN_RST;
            panel_screen_reg <= ODSS_SCREEN_RST;
            boot_done_reg <= 1'b0;
            entry_reg <= '0;
            srcs_reg <= '0;
            monitor_reg <= '0;
            sel_d_reg <= '0;
        end
        else
        begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            position_mode_reg <= position_mode_next;
            speed_display_reg <= speed_display_next;
            st_active_reg <= st_active_next;
            accel_active_reg <= accel_active_next;
            setter_screen_reg <= setter_screen_next;
            panel_screen_reg <= panel_screen_next;
            boot_done_reg <= boot_done_next;
            entry_reg <= entry_next;
            srcs_reg <= srcs_next;
            monitor_reg <= monitor_next;
            // aligns with the registered table read
            sel_d_reg <= entry_select;
        end
    end

    // no reset here: a write must survive the power-up that applies it
    always_ff @(posedge clock)
    begin
        setter_screen_cfg_reg <= setter_screen_cfg_next;
        panel_screen_cfg_reg <= panel_screen_cfg_next;
        st_pending_reg <= st_pending_next;
        accel_pending_reg <= accel_pending_next;
    end

    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign entry_out = entry_reg;
    assign entry_srcs = srcs_reg;
    assign speed_monitor = monitor_reg;
    assign setter_screen = setter_screen_reg;
    assign panel_screen = panel_screen_reg;
endmodule

// >>> odss_pkg.sv
// shared constants, register map and carrier types for operation data source select
package odss_pkg;

    localparam int unsigned ODSS_ENTRIES = 16;
    localparam int unsigned ODSS_ENTRY_W = 4;
    localparam int unsigned ODSS_DATA_W = 16;

    // register byte offsets
    localparam logic [7:0] ODSS_OFF_CONTROL = 8'h00;
    localparam logic [7:0] ODSS_OFF_SPEED_DISPLAY = 8'h04;
    localparam logic [7:0] ODSS_OFF_SETTER_SCREEN = 8'h08;
    localparam logic [7:0] ODSS_OFF_PANEL_SCREEN = 8'h0c;
    localparam logic [7:0] ODSS_OFF_SPEED_TORQUE_SRC = 8'h10;
    localparam logic [7:0] ODSS_OFF_ACCEL_SRC = 8'h14;
    localparam logic [7:0] ODSS_OFF_ACTIVE_SRC = 8'h18;
    // 16 entries of two words fill the upper half of the map
    localparam logic [7:0] ODSS_OFF_TABLE_BASE = 8'h80;
    localparam logic [7:0] ODSS_OFF_TABLE_END = 8'hfc;
    localparam logic [7:0] ODSS_OFF_SELECTED = 8'h40;
    localparam logic [7:0] ODSS_OFF_MONITOR = 8'h44;

    // field positions
    localparam int unsigned ODSS_CTRL_MODE_BIT = 0;
    localparam int unsigned ODSS_ENTRY_LSB = 0;
    localparam int unsigned ODSS_SEL2_W = 2;
    localparam int unsigned ODSS_SCREEN_W = 3;

    // reset values and screen code limit
    localparam logic [1:0] ODSS_SPEED_DISPLAY_RST = 2'h0;
    localparam logic [2:0] ODSS_SCREEN_RST = 3'h0;
    localparam logic [1:0] ODSS_SPEED_TORQUE_RST = 2'h1;
    localparam logic ODSS_ACCEL_RST = 1'b1;
    localparam logic [2:0] ODSS_SCREEN_MAX = 3'h5;

    // selector encodings
    localparam logic [1:0] ODSS_SIGN_SIGNED = 2'h0;
    localparam logic [1:0] ODSS_SIGN_ABS = 2'h1;
    localparam logic [1:0] ODSS_SIGN_INVERSE = 2'h2;
    localparam logic [1:0] ODSS_ST_DIGITAL = 2'h0;
    localparam logic [1:0] ODSS_ST_ANALOG_SPEED = 2'h1;
    localparam logic [1:0] ODSS_ST_TORQUE = 2'h2;
    localparam logic [3:0] ODSS_ENTRY0 = 4'h0;
    localparam logic [3:0] ODSS_ENTRY1 = 4'h1;

    localparam logic [1:0] ODSS_RESP_OKAY = 2'h0;
    localparam logic [1:0] ODSS_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ODSS_SRC_DIGITAL,
        ODSS_SRC_INT_POT,
        ODSS_SRC_EXT_ANALOG,
        ODSS_SRC_TIME_POT
    } odss_src_t;

    // analog samples from the converter side
    typedef struct packed {
        logic [15:0] int_pot_speed;
        logic [15:0] ext_analog;
        logic [15:0] accel_time_pot;
        logic [15:0] decel_time_pot;
    } odss_analog_t;

    // one resolved operation data entry
    typedef struct packed {
        logic [15:0] speed;
        logic [15:0] torque;
        logic [15:0] accel;
        logic [15:0] decel;
    } odss_entry_t;

    // source flags of the selected entry
    typedef struct packed {
        odss_src_t speed;
        odss_src_t torque;
        odss_src_t accel;
        odss_src_t decel;
    } odss_srcs_t;

endpackage

// >>> odss_table_mem.sv
// digital operation data table memory with registered read port
`timescale 1ns/1ps
module odss_table_mem #(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned ADDR_W = 4,
    parameter int unsigned DATA_W = 64
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [DATA_W-1:0] wr_mask,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;

    always_comb
    begin
        rd_data_next = mem[rd_addr];
    end

    // contents are not reset; software loads the table
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data_reg <= '0;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;
endmodule

// >>> odss_partner.sv
// far-side model: analog samples, run inputs and detected speed
`timescale 1ns/1ps
module odss_partner (
    input wire logic clock,
    input wire logic shuffle,
    output odss_pkg::odss_analog_t analog_in,
    output logic signed [15:0] detected_speed,
    output logic forward_run_input,
    output logic reverse_run_input
);
    import odss_pkg::*;
    initial
    begin
        analog_in = '0;
        detected_speed = 16'h0000;
        {forward_run_input, reverse_run_input} = 2'h0;
    end
    // new values only on request so a sample stays put while the bench looks
    always @(posedge clock)
    begin
        if (shuffle)
        begin
            analog_in <= odss_analog_t'({$urandom(), $urandom()});
            detected_speed <= 16'($urandom());
            {forward_run_input, reverse_run_input} <= 2'($urandom());
        end
    end
endmodule

// >>> odss_monitor.sv
// port checker for operation data source select
`timescale 1ns/1ps
module odss_monitor (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] entry_select,
    input wire odss_pkg::odss_srcs_t entry_srcs,
    input wire logic [2:0] setter_screen,
    input wire logic [2:0] panel_screen
);
    import odss_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not inverse of rvalid");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    a_setter_range: assert property (setter_screen <= ODSS_SCREEN_MAX)
        else $error("setter screen code out of range");
    a_panel_range: assert property (panel_screen <= ODSS_SCREEN_MAX)
        else $error("panel screen code out of range");
    a_upper_digital: assert property ($past(rst_b, 2) && $past(entry_select, 2) >= 4'h2 |->
        entry_srcs.speed == ODSS_SRC_DIGITAL && entry_srcs.accel == ODSS_SRC_DIGITAL)
        else $error("upper entry not digital");
    a_src_kinds: assert property (entry_srcs.speed != ODSS_SRC_TIME_POT && entry_srcs.torque inside
        {ODSS_SRC_DIGITAL, ODSS_SRC_EXT_ANALOG})
        else $error("impossible source kind");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_int_pot: cover property (entry_srcs.speed == ODSS_SRC_INT_POT);
    c_ext_torque: cover property (entry_srcs.torque == ODSS_SRC_EXT_ANALOG);
    c_time_pot: cover property (entry_srcs.accel == ODSS_SRC_TIME_POT);
endmodule

// >>> test_operation_data_source_select.sv
// self-checking bench for operation data source select
`timescale 1ns/1ps
module test_operation_data_source_select;
    import odss_pkg::*;
    logic clock, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, forward_run_input, reverse_run_input, shuffle;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, entry_select;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, st, ac, disp;
    logic [2:0] setter_screen, panel_screen;
    logic [15:0] speed_monitor, mag;
    logic signed [15:0] detected_speed;
    odss_analog_t analog_in;
    odss_entry_t entry_out;
    odss_srcs_t entry_srcs;
    logic [31:0] t_lo [16];
    logic [31:0] t_hi [16];
    int n_errors = 0, compares = 0, m, prev = 5;
    odss_top uut (.*);
    odss_partner far_side (.*);
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ready is looked at on the falling edge, where it equals the value seen by the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic at, wt, bt;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(negedge clock);
            {at, wt, bt, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge clock);
            if (at && s_axi_awvalid)
                s_axi_awvalid <= 1'b0;
            if (wt && s_axi_wvalid)
                s_axi_wvalid <= 1'b0;
        end
        while (!bt);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic at, rt;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(negedge clock);
            {at, rt, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clock);
            if (at && s_axi_arvalid)
                s_axi_arvalid <= 1'b0;
        end
        while (!rt);
    endtask
    task automatic power_up;
        rst_b <= 1'b0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
    endtask
    function automatic logic [71:0] model(input int e);
        logic [15:0] sp, tq, a, d;
        logic [1:0] ss, ts, as;
        {sp, tq, a, d, ss, ts, as} = {t_lo[e], t_hi[e], 6'h00};
        if (m == 0 && st == 2'h1 && e < 2)
            {ss, sp} = e ? {2'h2, analog_in.ext_analog} : {2'h1, analog_in.int_pot_speed};
        if (st == 2'h2 && (m == 1 || e == 0))
            {ts, tq} = {2'h2, analog_in.ext_analog};
        if (m == 0 && ac == 2'h1 && e < 2)
            {as, a, d} = {2'h3, analog_in.accel_time_pot, analog_in.decel_time_pot};
        return {sp, tq, a, d, ss, ts, as, as};
    endfunction
    ////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        n_errors++;
        print_verdict;
    end
    initial
    begin
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, shuffle, entry_select} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_bready, s_axi_rready} = {48'h0, 4'hf, 2'h3};
        void'($urandom(87));
        power_up;
        rd(ODSS_OFF_SPEED_TORQUE_SRC, rv, rr);
        chk(rv, 32'h1);
        rd(ODSS_OFF_ACTIVE_SRC, rv, rr);
        chk(rv, 32'h5);
        chk(panel_screen, 3'h0);
        for (int e = 0; e < 16; e++)
        begin
            {t_lo[e], t_hi[e]} = {$urandom(), $urandom()};
            wr(ODSS_OFF_TABLE_BASE + 8'(8 * e), t_lo[e], rr);
            wr(ODSS_OFF_TABLE_BASE + 8'(8 * e + 4), t_hi[e], rr);
        end
        wr(8'h30, 32'h0, rr);
        chk(rr, ODSS_RESP_SLVERR);
        rd(8'h30, rv, rr);
        chk({rv, rr}, {32'h0, ODSS_RESP_SLVERR});
        wr(ODSS_OFF_SETTER_SCREEN, 32'h5, rr);
        wr(ODSS_OFF_PANEL_SCREEN, 32'h7, rr);
        for (int c = 0; c < 12; c++)
        begin
            {m, st, ac} = {c / 6, 2'((c / 2) % 3), 2'(c % 2)};
            wr(ODSS_OFF_SPEED_TORQUE_SRC, 32'(st), rr);
            wr(ODSS_OFF_ACCEL_SRC, 32'(ac), rr);
            rd(ODSS_OFF_ACTIVE_SRC, rv, rr);
            chk(rv, 32'(prev));
            power_up;
            wr(ODSS_OFF_CONTROL, 32'(m), rr);
            rd(ODSS_OFF_ACTIVE_SRC, rv, rr);
            prev = {ac[0], st};
            chk(rv, 32'(prev));
            chk({setter_screen, panel_screen}, 6'h28);
            for (int e = 0; e < 16; e++)
            begin
                entry_select <= 4'(e);
                shuffle <= 1'b1;
                @(posedge clock);
                shuffle <= 1'b0;
                repeat (4) @(posedge clock);
                chk({entry_out, entry_srcs}, model(e));
            end
        end
        for (int i = 0; i < 12; i++)
        begin
            disp = 2'(i % 3);
            wr(ODSS_OFF_SPEED_DISPLAY, 32'(disp), rr);
            shuffle <= 1'b1;
            @(posedge clock);
            shuffle <= 1'b0;
            repeat (3) @(posedge clock);
            mag = detected_speed < 0 ? -detected_speed : detected_speed;
            if ((disp == 2'h0 && reverse_run_input) || (disp == 2'h2 && forward_run_input))
                mag = -mag;
            chk(speed_monitor, mag);
        end
        print_verdict;
    end
endmodule
bind odss_top odss_monitor mon (.*);
